// [core/ext_mem_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module ext_mem_ctrl #(
    parameter int NSPACE = ext_mem_pkg::NSPACE
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // clocking setup
    input wire logic [1:0] port_clk_src,
    input wire logic [1:0] second_div_sel,
    input wire logic port_clock_in_pin,
    // per-space timing
    input wire ext_mem_pkg::space_cfg_s space_cfg [NSPACE],
    // request and response
    input wire logic req_valid,
    input wire ext_mem_pkg::req_s req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [ext_mem_pkg::DATA_W-1:0] rsp_rdata,
    // memory clocks
    output logic mem_clock_out_first,
    output logic mem_clock_out_second,
    // memory pins
    output logic [NSPACE-1:0] space_chip_select_n,
    output logic [ext_mem_pkg::BE_W-1:0] byte_lane_enables_n,
    output logic [ext_mem_pkg::ADDR_W-1:0] ext_addr_lines,
    output logic [ext_mem_pkg::DATA_W-1:0] ext_data_out,
    output logic ext_data_oe_n,
    input wire logic [ext_mem_pkg::DATA_W-1:0] ext_data_in,
    output logic oe_pin_n,
    output logic re_pin_n,
    output logic we_pin_n,
    input wire logic ext_ready_in
);

    // =====================================================
    // port clock and memory output clocks
    logic [2:0] pin_sync_q;
    logic pin_lvl_q;
    logic [2:0] div_cnt_q;
    logic div_lvl_q;
    logic sec_cnt_q;
    logic pclk_d;
    logic prise;
    logic [2:0] half;

    assign half = (port_clk_src == ext_mem_pkg::SRC_DIV6) ? ext_mem_pkg::DIV6_HALF
                                                          : ext_mem_pkg::DIV4_HALF;
    assign pclk_d = (port_clk_src == ext_mem_pkg::SRC_DIV4 ||
                     port_clk_src == ext_mem_pkg::SRC_DIV6) ? div_lvl_q : pin_lvl_q;
    assign prise = pclk_d & ~mem_clock_out_first;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_sync_q <= 3'h0;
            pin_lvl_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], port_clock_in_pin};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_lvl_q <= pin_sync_q[2];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_cnt_q <= 3'h0;
            div_lvl_q <= 1'b0;
        end else if (div_cnt_q >= half - 3'h1) begin
            div_cnt_q <= 3'h0;
            div_lvl_q <= ~div_lvl_q;
        end else begin
            div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_clock_out_first <= 1'b0;
            mem_clock_out_second <= 1'b0;
            sec_cnt_q <= 1'b0;
        end else begin
            mem_clock_out_first <= pclk_d;
            if (second_div_sel == ext_mem_pkg::DIV_N1) begin
                mem_clock_out_second <= pclk_d;
            end else if (prise) begin
                sec_cnt_q <= ~sec_cnt_q;
                if (second_div_sel == ext_mem_pkg::DIV_N2 || sec_cnt_q) begin
                    mem_clock_out_second <= ~mem_clock_out_second;
                end
            end
        end
    end

    // =====================================================
    // access timing tick and ready synchroniser
    ext_mem_pkg::space_cfg_s cfg_q;
    ext_mem_pkg::req_s cur_q;
    logic sel_clk;
    logic sel_prev_q;
    logic tick;
    logic [2:0] rdy_sync_q;
    logic rdy_q;

    assign sel_clk = cfg_q.sync_clock_select ? mem_clock_out_second : mem_clock_out_first;
    assign tick = sel_clk & ~sel_prev_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sel_prev_q <= 1'b0;
            rdy_sync_q <= 3'h7;
            rdy_q <= 1'b1;
        end else begin
            sel_prev_q <= sel_clk;
            rdy_sync_q <= {rdy_sync_q[1:0], ext_ready_in};
            if (rdy_sync_q[1] == rdy_sync_q[2]) begin
                rdy_q <= rdy_sync_q[2];
            end
        end
    end

    // =====================================================
    // access sequencer
    ext_mem_pkg::acc_state_e state_q;
    logic [ext_mem_pkg::CNT_W-1:0] cnt_q;
    logic [1:0] lat_q;
    logic seen_low_q;
    logic in_win;
    logic stall;
    logic restart;
    logic strobe_end;
    logic accept;
    ext_mem_pkg::space_cfg_s new_cfg;

    function automatic logic [ext_mem_pkg::CNT_W-1:0] min1(
        input logic [ext_mem_pkg::CNT_W-1:0] x);
        return (x == '0) ? ext_mem_pkg::CNT_ONE : x;
    endfunction

    assign new_cfg = space_cfg[req.space];
    assign accept = req_valid && req_ready && state_q == ext_mem_pkg::ST_IDLE;
    assign in_win = cnt_q <= ext_mem_pkg::STROBE_TAIL;
    assign stall = in_win && !rdy_q;
    assign restart = in_win && seen_low_q && rdy_q;
    assign strobe_end = cnt_q == ext_mem_pkg::CNT_ONE && !stall && !restart;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= ext_mem_pkg::ST_IDLE;
            cnt_q <= '0;
            lat_q <= 2'h0;
            seen_low_q <= 1'b0;
            cur_q <= '0;
            cfg_q <= '0;
        end else if (state_q == ext_mem_pkg::ST_IDLE) begin
            if (accept) begin
                cur_q <= req;
                cfg_q <= new_cfg;
                seen_low_q <= 1'b0;
                cnt_q <= min1(req.write ? new_cfg.write_setup_cycles
                                        : new_cfg.read_setup_cycles);
                state_q <= req.sync ? ext_mem_pkg::ST_SCMD : ext_mem_pkg::ST_ASETUP;
            end
        end else if (tick) begin
            unique case (state_q)
                ext_mem_pkg::ST_ASETUP: begin
                    if (cnt_q == ext_mem_pkg::CNT_ONE) begin
                        state_q <= ext_mem_pkg::ST_ASTROBE;
                        cnt_q <= min1(cur_q.write ? cfg_q.write_strobe_cycles
                                                  : cfg_q.read_strobe_cycles);
                    end else begin
                        cnt_q <= cnt_q - ext_mem_pkg::CNT_ONE;
                    end
                end
                ext_mem_pkg::ST_ASTROBE: begin
                    if (stall) begin
                        seen_low_q <= 1'b1;
                    end else if (restart) begin
                        seen_low_q <= 1'b0;
                        cnt_q <= ext_mem_pkg::STROBE_TAIL;
                    end else if (strobe_end) begin
                        state_q <= ext_mem_pkg::ST_AHOLD;
                        cnt_q <= min1(cur_q.write ? cfg_q.write_hold_cycles
                                                  : cfg_q.read_hold_cycles);
                    end else begin
                        cnt_q <= cnt_q - ext_mem_pkg::CNT_ONE;
                    end
                end
                ext_mem_pkg::ST_AHOLD: begin
                    if (cnt_q == ext_mem_pkg::CNT_ONE) begin
                        state_q <= ext_mem_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - ext_mem_pkg::CNT_ONE;
                    end
                end
                ext_mem_pkg::ST_SCMD: begin
                    state_q <= ext_mem_pkg::ST_SWAIT;
                    lat_q <= cur_q.write ? cfg_q.sync_write_latency
                                         : cfg_q.sync_read_latency;
                end
                ext_mem_pkg::ST_SWAIT: begin
                    if (lat_q == 2'h0) begin
                        state_q <= cfg_q.read_enable_mode ? ext_mem_pkg::ST_IDLE
                                                          : ext_mem_pkg::ST_SDESEL;
                    end else begin
                        lat_q <= lat_q - 2'h1;
                    end
                end
                default: begin
                    state_q <= ext_mem_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // request handshake and read data capture
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            req_ready <= state_q == ext_mem_pkg::ST_IDLE && !accept;
            rsp_valid <= 1'b0;
            if (tick && !cur_q.write &&
                ((state_q == ext_mem_pkg::ST_ASTROBE && strobe_end) ||
                 (state_q == ext_mem_pkg::ST_SWAIT && lat_q == 2'h0))) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= ext_data_in;
            end
        end
    end

    // =====================================================
    // memory pins
    logic async_act;
    logic sync_act;

    assign async_act = state_q == ext_mem_pkg::ST_ASETUP || state_q == ext_mem_pkg::ST_ASTROBE ||
                       state_q == ext_mem_pkg::ST_AHOLD;
    assign sync_act = state_q == ext_mem_pkg::ST_SCMD || state_q == ext_mem_pkg::ST_SWAIT;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            space_chip_select_n <= '1;
            byte_lane_enables_n <= '1;
            ext_addr_lines <= '0;
            ext_data_out <= '0;
            ext_data_oe_n <= 1'b1;
            oe_pin_n <= 1'b1;
            re_pin_n <= 1'b1;
            we_pin_n <= 1'b1;
        end else begin
            space_chip_select_n <= '1;
            if (async_act || state_q == ext_mem_pkg::ST_SCMD ||
                (state_q == ext_mem_pkg::ST_SWAIT && cfg_q.select_extend && !cur_q.write)) begin
                space_chip_select_n[cur_q.space] <= 1'b0;
            end
            if (async_act || sync_act) begin
                byte_lane_enables_n <= ~cur_q.be;
                ext_addr_lines <= cur_q.addr;
                ext_data_out <= cur_q.wdata;
            end else begin
                byte_lane_enables_n <= '1;
            end
            ext_data_oe_n <= !((async_act || sync_act) && cur_q.write);
            oe_pin_n <= !((async_act || sync_act) && !cur_q.write);
            re_pin_n <= !((state_q == ext_mem_pkg::ST_ASTROBE && !cur_q.write) ||
                          (state_q == ext_mem_pkg::ST_SCMD &&
                           (!cfg_q.read_enable_mode || !cur_q.write)));
            we_pin_n <= !((state_q == ext_mem_pkg::ST_ASTROBE ||
                           state_q == ext_mem_pkg::ST_SCMD) && cur_q.write);
        end
    end

    // =====================================================
    // assertions
    property p_idle_pins;
        @(posedge clk_sys) disable iff (!rstn)
        $past(state_q) == ext_mem_pkg::ST_IDLE |-> &space_chip_select_n && re_pin_n && we_pin_n;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("pins not idle");

    property p_ready_sync;
        @(posedge clk_sys) disable iff (!rstn)
        $changed(rdy_q) |-> $past(rdy_sync_q[1] == rdy_sync_q[2]);
    endproperty
    a_ready_sync: assert property (p_ready_sync) else $error("ready used unsynchronised");

    property p_stall;
        @(posedge clk_sys) disable iff (!rstn)
        tick && state_q == ext_mem_pkg::ST_ASTROBE && in_win && !rdy_q
        |=> state_q == ext_mem_pkg::ST_ASTROBE && cnt_q == $past(cnt_q);
    endproperty
    a_stall: assert property (p_stall) else $error("strobe not stretched");

    property p_restart;
        @(posedge clk_sys) disable iff (!rstn)
        tick && state_q == ext_mem_pkg::ST_ASTROBE && restart |=> cnt_q == ext_mem_pkg::STROBE_TAIL;
    endproperty
    a_restart: assert property (p_restart) else $error("strobe end not two after ready");

    property p_capture;
        @(posedge clk_sys) disable iff (!rstn)
        tick && state_q == ext_mem_pkg::ST_ASTROBE && strobe_end && !cur_q.write
        |=> rsp_valid && rsp_rdata == $past(ext_data_in);
    endproperty
    a_capture: assert property (p_capture) else $error("read data not captured");

    property p_div4;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(mem_clock_out_first) && port_clk_src == ext_mem_pkg::SRC_DIV4 &&
        $past(port_clk_src, 5) == ext_mem_pkg::SRC_DIV4
        |-> $past(mem_clock_out_first, 4) && !$past(mem_clock_out_first, 2);
    endproperty
    a_div4: assert property (p_div4) else $error("first clock period wrong");

    property p_div2;
        @(posedge clk_sys) disable iff (!rstn)
        second_div_sel == ext_mem_pkg::DIV_N2 && $past(second_div_sel) == ext_mem_pkg::DIV_N2 &&
        $changed(mem_clock_out_second) |-> $past(prise);
    endproperty
    a_div2: assert property (p_div2) else $error("second clock off port clock");

    property p_cs_drop;
        @(posedge clk_sys) disable iff (!rstn)
        state_q == ext_mem_pkg::ST_SWAIT && !cfg_q.select_extend |=> &space_chip_select_n;
    endproperty
    a_cs_drop: assert property (p_cs_drop) else $error("chip select held");

    property p_cs_ext;
        @(posedge clk_sys) disable iff (!rstn)
        state_q == ext_mem_pkg::ST_SWAIT && cfg_q.select_extend && !cur_q.write
        |=> !(&space_chip_select_n) && !oe_pin_n;
    endproperty
    a_cs_ext: assert property (p_cs_ext) else $error("chip select not extended");

    property p_no_desel;
        @(posedge clk_sys) disable iff (!rstn)
        state_q == ext_mem_pkg::ST_SDESEL |-> !cfg_q.read_enable_mode;
    endproperty
    a_no_desel: assert property (p_no_desel) else $error("deselect in fifo mode");

    property p_cov_stall;
        @(posedge clk_sys) disable iff (!rstn) tick && restart;
    endproperty
    c_cov_stall: cover property (p_cov_stall);

    property p_cov_sread;
        @(posedge clk_sys) disable iff (!rstn) rsp_valid && cur_q.sync;
    endproperty
    c_cov_sread: cover property (p_cov_sread);

    property p_cov_awrite;
        @(posedge clk_sys) disable iff (!rstn) !we_pin_n && !cur_q.sync;
    endproperty
    c_cov_awrite: cover property (p_cov_awrite);

endmodule
`default_nettype wire

// [core/ext_mem_pkg.sv]
`default_nettype none
package ext_mem_pkg;

    // =====================================================
    // widths and counts
    localparam int NSPACE = 4;
    localparam int CNT_W = 6;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    // ready window and restart count before strobe end
    localparam logic [CNT_W-1:0] STROBE_TAIL = 6'h02;

    // =====================================================
    // port clock source and second clock divider codes
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_DIV4 = 2'h1;
    localparam logic [1:0] SRC_DIV6 = 2'h2;
    localparam logic [2:0] DIV4_HALF = 3'h2;
    localparam logic [2:0] DIV6_HALF = 3'h3;
    localparam logic [1:0] DIV_N1 = 2'h0;
    localparam logic [1:0] DIV_N2 = 2'h1;
    localparam logic [1:0] DIV_N4 = 2'h2;

    // =====================================================
    // types
    typedef struct packed {
        logic [CNT_W-1:0] read_setup_cycles;
        logic [CNT_W-1:0] read_strobe_cycles;
        logic [CNT_W-1:0] read_hold_cycles;
        logic [CNT_W-1:0] write_setup_cycles;
        logic [CNT_W-1:0] write_strobe_cycles;
        logic [CNT_W-1:0] write_hold_cycles;
        logic [1:0] sync_read_latency;
        logic [1:0] sync_write_latency;
        logic select_extend;
        logic read_enable_mode;
        logic sync_clock_select;
    } space_cfg_s;

    typedef struct packed {
        logic write;
        logic sync;
        logic [1:0] space;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0] be;
        logic [DATA_W-1:0] wdata;
    } req_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ASETUP, ST_ASTROBE, ST_AHOLD, ST_SCMD, ST_SWAIT, ST_SDESEL
    } acc_state_e;

endpackage
`default_nettype wire

// [verification/mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // memory pins
    input wire logic [3:0] cs_n,
    input wire logic [3:0] be_n,
    input wire logic [19:0] addr,
    input wire logic [31:0] dout,
    input wire logic oe_n,
    input wire logic re_n,
    input wire logic we_n,
    output logic [31:0] din,
    output logic rdy,
    // cycles of ready low per strobe
    input wire logic [7:0] rdy_low
);
    logic [31:0] mem [16];
    logic [31:0] last_q;
    logic [3:0] a_q;
    logic [7:0] hold_q;
    logic [7:0] low_q;
    logic st_q;
    logic sel;
    // ==========================================
    // data and ready pins
    assign sel = (cs_n != 4'hF);
    // a released bus shows the inverse of its last value
    assign din = (hold_q != 8'h00) ? mem[a_q] : ~last_q;
    assign rdy = (low_q == 8'h00);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            last_q <= 32'h0;
            hold_q <= 8'h00;
            low_q <= 8'h00;
            st_q <= 1'b0;
            a_q <= 4'h0;
        end else begin
            last_q <= din;
            st_q <= !re_n || !we_n;
            if (sel && !oe_n) begin
                a_q <= addr[3:0];
                hold_q <= 8'h28;
            end else if (hold_q != 8'h00) begin
                hold_q <= hold_q - 8'h01;
            end
            // ready stays low a whole run of cycles, never a glitch
            if ((!re_n || !we_n) && !st_q) begin
                low_q <= rdy_low;
            end else if (low_q != 8'h00) begin
                low_q <= low_q - 8'h01;
            end
            if (sel && !we_n) begin
                for (int i = 0; i < 4; i++) begin
                    if (!be_n[i]) begin
                        mem[addr[3:0]][8*i +: 8] <= dout[8*i +: 8];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========================================
    // signals
    logic clk_sys, rstn, pin, req_valid;
    logic [1:0] src, div;
    logic [2:0] pcnt = 3'h0;
    logic [7:0] rdy_low;
    ext_mem_pkg::space_cfg_s cfg [4];
    ext_mem_pkg::req_s req;
    logic req_ready, rsp_valid, c1, c2, oe_n, re_n, we_n, rdy, bad, doe_n;
    logic [31:0] rsp_rdata, dout, din, rd;
    logic [3:0] cs_n, be_n;
    logic [19:0] addr;
    int error_cnt, n_compared, n_cs, n_re, n_we, n_oe, n_cmd;
    int t_rsp, t_cmd, t_str, t_cs, t_end, d0, w0, b1;
    int ct [7][5] = '{'{1, 0, 0, 2, 2}, '{1, 0, 1, 2, 2}, '{2, 1, 0, 3, 3}, '{2, 1, 1, 6, 6},
        '{0, 2, 0, 3, 5}, '{0, 2, 1, 16, 16}, '{1, 2, 1, 8, 8}};

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        pcnt <= pcnt + 3'h1;
        pin <= (pcnt < 3'h3);
    end

    ext_mem_ctrl i_dut (.clk_sys(clk_sys), .rstn(rstn), .port_clk_src(src),
        .second_div_sel(div), .port_clock_in_pin(pin), .space_cfg(cfg),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_clock_out_first(c1), .mem_clock_out_second(c2),
        .space_chip_select_n(cs_n), .byte_lane_enables_n(be_n), .ext_addr_lines(addr),
        .ext_data_out(dout), .ext_data_oe_n(doe_n), .ext_data_in(din), .oe_pin_n(oe_n),
        .re_pin_n(re_n), .we_pin_n(we_n), .ext_ready_in(rdy));
    mem_model i_mem (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .be_n(be_n),
        .addr(addr), .dout(dout), .oe_n(oe_n), .re_n(re_n), .we_n(we_n), .din(din),
        .rdy(rdy), .rdy_low(rdy_low));

    // ==========================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic setcfg(input int s, st, h, l, input logic ext, md, sel);
        for (int i = 0; i < 4; i++) begin
            cfg[i] <= '{6'(s), 6'(st), 6'(h), 6'(s), 6'(st), 6'(h), 2'(l), 2'(l), ext, md, sel};
        end
        @(posedge clk_sys);
    endtask

    // one access, pins watched cycle by cycle until idle again
    task automatic acc(input logic wr, sy, input logic [1:0] sp, input logic [19:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        int k;
        {n_cs, n_re, n_we, n_oe, n_cmd, t_rsp, t_cmd, t_str, t_cs} = '0;
        bad = 1'b0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{wr, sy, sp, a, be, d};
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (req_ready !== 1'b1 && k < 100);
        req_valid <= 1'b0;
        if (req_ready !== 1'b1) error_cnt++;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
            if (cs_n[sp] === 1'b0) begin
                n_cs++;
                t_cs = k;
                if (addr !== a || be_n !== ~be || (wr && dout !== d) || doe_n !== !wr) bad = 1'b1;
            end
            if ((cs_n | (4'h1 << sp)) !== 4'hF) bad = 1'b1;
            if (re_n === 1'b0) n_re++;
            if (we_n === 1'b0) n_we++;
            if (oe_n === 1'b0) n_oe++;
            if (re_n === 1'b0 || we_n === 1'b0) t_str = k;
            if (re_n === 1'b0 || we_n === 1'b0) begin
                n_cmd++;
                t_cmd = k;
            end
            if (rsp_valid === 1'b1) begin
                t_rsp = k;
                rd = rsp_rdata;
            end
        end while ((req_ready !== 1'b1 || k < 3) && k < 400);
        t_end = k;
        if (k >= 400) begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic mclk(input logic sec, input int hi, input int lo);
        int h;
        int l;
        int k;
        h = 0;
        l = 0;
        for (k = 0; k < 40 && (sec ? c2 : c1) !== 1'b0; k++) @(posedge clk_sys);
        for (k = 0; k < 40 && (sec ? c2 : c1) !== 1'b1; k++) @(posedge clk_sys);
        for (h = 0; h < 40 && (sec ? c2 : c1) === 1'b1; h++) @(posedge clk_sys);
        for (l = 0; l < 40 && (sec ? c2 : c1) === 1'b0; l++) @(posedge clk_sys);
        chk("clock high", h, hi);
        chk("clock low", l, lo);
    endtask

    // ==========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        {src, div, req_valid, req, rdy_low, error_cnt, n_compared} = '0;
        for (int i = 0; i < 4; i++) cfg[i] = '0;
        repeat (5) @(posedge clk_sys);
        chk("idle pins", {cs_n, oe_n, re_n, we_n}, 7'h7F);
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 7; i++) begin
            src <= 2'(ct[i][0]);
            div <= 2'(ct[i][1]);
            repeat (40) @(posedge clk_sys);
            mclk(ct[i][2][0], ct[i][3], ct[i][4]);
        end
        src <= ext_mem_pkg::SRC_DIV4;
        div <= ext_mem_pkg::DIV_N2;
        repeat (40) @(posedge clk_sys);
        $display("test clocks done");
        setcfg(2, 3, 2, 0, 1'b0, 1'b1, 1'b0);
        acc(1'b1, 1'b0, 2'h1, 20'h5, 4'hF, 32'h12345678);
        chk("write strobe", n_we, 12);
        chk("write hold", t_cs - t_str, 8);
        chk("write selects", bad, 0);
        chk("write roles", {n_re != 0, n_oe != 0}, 0);
        acc(1'b1, 1'b0, 2'h1, 20'h5, 4'h2, 32'hAAAAAAAA);
        acc(1'b0, 1'b0, 2'h1, 20'h5, 4'hF, 32'h0);
        chk("async rdata", rd, 32'h1234AA78);
        chk("read strobe", n_re, 12);
        chk("oe with select", n_oe, n_cs);
        chk("read selects", {bad, n_we != 0}, 0);
        $display("test async done");
        setcfg(1, 6, 1, 0, 1'b0, 1'b1, 1'b0);
        rdy_low <= 8'd8;
        acc(1'b0, 1'b0, 2'h2, 20'h5, 4'hF, 32'h0);
        chk("early ready", n_re, 24);
        setcfg(1, 4, 1, 0, 1'b0, 1'b1, 1'b0);
        rdy_low <= 8'd40;
        acc(1'b0, 1'b0, 2'h3, 20'h5, 4'hF, 32'h0);
        chk("stretch range", {n_re >= 48, n_re <= 64}, 2'h3);
        chk("stretch ticks", n_re % 4, 0);
        chk("stretch rdata", rd, 32'h1234AA78);
        rdy_low <= 8'd0;
        $display("test ready done");
        for (int l = 0; l < 4; l++) begin
            setcfg(1, 1, 1, l, 1'b0, 1'b1, 1'b0);
            acc(1'b1, 1'b1, 2'(l), 20'(l), 4'hF, 32'hC0DE0000 + 32'(l));
            if (l == 0) w0 = t_end - t_cmd;
            chk("write latency", t_end - t_cmd - w0, 4 * l);
            chk("sync write pins", {n_oe != 0, n_we == 0, n_cs != n_cmd}, 0);
            chk("no read enable", n_re, 0);
            acc(1'b0, 1'b1, 2'(l), 20'(l), 4'hF, 32'h0);
            if (l == 0) d0 = t_rsp - t_cmd;
            if (l == 0) b1 = t_end - t_cmd;
            chk("read latency", t_rsp - t_cmd - d0, 4 * l);
            chk("sync rdata", rd, 32'hC0DE0000 + 32'(l));
            chk("sync read pins", {n_we != 0, n_oe == 0, n_cs != n_cmd}, 0);
        end
        setcfg(1, 1, 1, 0, 1'b0, 1'b0, 1'b0);
        acc(1'b0, 1'b1, 2'h0, 20'h0, 4'hF, 32'h0);
        chk("deselect tick", t_end - t_cmd - b1, 4);
        acc(1'b1, 1'b1, 2'h0, 20'h7, 4'hF, 32'h0BADF00D);
        chk("address strobe", n_re, n_we);
        setcfg(1, 1, 1, 2, 1'b1, 1'b1, 1'b0);
        acc(1'b0, 1'b1, 2'h1, 20'h2, 4'hF, 32'h0);
        chk("select extend", n_cs - n_cmd, 12);
        chk("extend rdata", rd, 32'hC0DE0002);
        setcfg(1, 1, 1, 0, 1'b0, 1'b1, 1'b1);
        acc(1'b0, 1'b1, 2'h2, 20'h3, 4'hF, 32'h0);
        chk("second clock sync", t_rsp - t_cmd, d0 + 4);
        setcfg(1, 3, 1, 0, 1'b0, 1'b1, 1'b1);
        acc(1'b0, 1'b0, 2'h3, 20'h7, 4'hF, 32'h0);
        chk("second clock strobe", n_re, 24);
        chk("second clock rdata", rd, 32'h0BADF00D);
        $display("test sync done");
        close_out();
    end
endmodule
`default_nettype wire
